/* File: inc/ulcs_defs.svh */
/*
  Register offsets, FIFO depth, reset values and timing counts for the UART line control block.
  Assumes inclusion by bare name from the package and the design file.
*/
`ifndef ULCS_DEFS_SVH
`define ULCS_DEFS_SVH
`define ULCS_OFS_LINE_CONTROL 8'h00
`define ULCS_OFS_LINE_STATUS 8'h04
`define ULCS_OFS_DATA_PORT 8'h08
`define ULCS_OFS_RX_THRESH 8'h0c
`define ULCS_OFS_TX_THRESH 8'h10
`define ULCS_OFS_HS_THRESH 8'h14
`define ULCS_OFS_BIT_RATE 8'h18
`define ULCS_FIFO_DEPTH 6'h20
`define ULCS_CTRL_RESET 32'h0000_0000
`define ULCS_BR_RESET 32'h0001_0010
`define ULCS_OVERSAMPLE 4'hf
`define ULCS_START_MID 4'h7
`endif

/* File: inc/ulcs_pkg.sv */
/*
  Types of the UART line control block.
  Assumes ulcs_defs.svh is reachable on the include path.
*/
`include "ulcs_defs.svh"
package ulcs_pkg;
  typedef struct packed {
    logic [21:0] unused;
    logic handshake_polarity;
    logic handshake_enable;
    logic transmit_enable;
    logic receive_enable;
    logic parity_on;
    logic even_parity_select;
    logic dual_stop_select;
    logic force_break;
    logic [1:0] spare;
  } ulcs_ctrl_s;
  typedef struct packed {
    logic [15:0] divider_modulus;
    logic [15:0] divider_increment;
  } ulcs_br_s;
  typedef struct packed {
    logic [7:0] data;
    logic stop_err;
    logic par_err;
    logic start_err;
  } ulcs_rx_entry_s;
  typedef enum logic [4:0] {
    TX_IDLE = 5'h01,
    TX_START = 5'h02,
    TX_DATA = 5'h04,
    TX_PAR = 5'h08,
    TX_STOP = 5'h10
  } ulcs_tx_e;
  typedef enum logic [4:0] {
    RX_IDLE = 5'h01,
    RX_START = 5'h02,
    RX_DATA = 5'h04,
    RX_PAR = 5'h08,
    RX_STOP = 5'h10
  } ulcs_rx_e;
endpackage : ulcs_pkg

/* File: logic/ulcs_uart.sv */
/*
  UART with register port, 32-entry transmit and receive FIFOs, parity, break and RTS/CTS flow control.
  Assumes a synchronous master on mclk with one-cycle strobes; rxd and rts pins are asynchronous.
*/
`include "ulcs_defs.svh"
`timescale 1ns/10ps
`default_nettype none
// Contract
// R1: Force-break bit drives the serial output low continuously.
// R2: Dual-stop bit sends two stop bits; receiver accepts one or more.
// R3: Even-parity bit low selects odd parity, high even; ignored without parity.
// R4: Parity-on enables both transmit generation and receive checking.
// R5: Enabled receiver needs a one-to-zero transition before any character.
// R6: Receive-enable cleared mid-character lets that character finish first.
// R7: Transmit-enable cleared mid-character returns the output high at once.
// R8: Data-port writes are discarded while transmit is disabled.
// R9: Irq bits 7:6 follow their cause; error bits 5:0 clear on status read.
// R10: Reading an empty receive FIFO sets the underrun flag.
// R11: Character arriving at full receive FIFO is discarded, overrun flag set.
// R12: Write to full transmit FIFO dropped, sets transmit overrun, no interrupt.
// R13: Stop-bit error flag follows the character popped from the receive FIFO.
// R14: Parity mismatch flag follows popped character; zero while parity is off.
// R15: Start-bit error flag set when start level not confirmed at bit centre.
// R16: Data port moves one byte in bits 7:0; upper bits read zero.
// R17: Receive fill count reports 0 to 32 bytes held.
// R18: Receive irq pending while fill count exceeds receive threshold.
// R19: Transmit free count reports 32 when empty down to 0 when full.
// R20: Transmit irq pending while free count exceeds transmit threshold.
// R21: Clear-to-send deasserted while fill count exceeds handshake threshold.
// R22: Without handshake the RTS input is ignored and CTS held asserted.
// R23: Remote not ready: finish current character, then pause.
// R24: Remote should stop sending soon after clear-to-send drops.
// R25: Bit-rate tick from a fractional divider with increment and modulus.
module ulcs_uart (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic rxd,
  input wire logic rts,
  output logic txd,
  output logic cts
);
  // ==========================================================
  // Registers and synchronisers
  ulcs_pkg::ulcs_ctrl_s ctrl_reg;
  ulcs_pkg::ulcs_br_s br_reg;
  logic [5:0] rx_thresh_reg;
  logic [7:0] tx_thresh_reg;
  logic [7:0] hs_thresh_reg;
  logic [5:0] err_reg;
  logic [7:0] rx_byte_reg;
  logic [1:0] rxd_sync_reg;
  logic [1:0] rts_sync_reg;
  logic [2:0] vote_reg;
  logic rx_bit;
  logic remote_ready;
  logic status_rd;
  logic data_wr;
  logic data_rd;

  assign status_rd = reg_rd && (reg_addr == `ULCS_OFS_LINE_STATUS);
  assign data_wr = reg_wr && (reg_addr == `ULCS_OFS_DATA_PORT);
  assign data_rd = reg_rd && (reg_addr == `ULCS_OFS_DATA_PORT);

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      rxd_sync_reg <= 2'h3;
      rts_sync_reg <= 2'h3;
      vote_reg <= 3'h7;
    end else begin
      rxd_sync_reg <= {rxd_sync_reg[0], rxd};
      rts_sync_reg <= {rts_sync_reg[0], rts};
      vote_reg <= {vote_reg[1:0], rxd_sync_reg[1]};
    end
  end
  // Two-of-three majority cleans short glitches off the line
  assign rx_bit = (vote_reg[0] & vote_reg[1]) | (vote_reg[1] & vote_reg[2]) | (vote_reg[0] & vote_reg[2]);
  // Polarity low: rts low means ready
  assign remote_ready = !ctrl_reg.handshake_enable ||
                        (rts_sync_reg[1] == ctrl_reg.handshake_polarity); // see R22 see R23

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      ctrl_reg <= `ULCS_CTRL_RESET;
      br_reg <= `ULCS_BR_RESET;
      rx_thresh_reg <= 6'h00;
      tx_thresh_reg <= 8'h00;
      hs_thresh_reg <= 8'h00;
    end else if (reg_wr) begin
      unique case (reg_addr)
        `ULCS_OFS_LINE_CONTROL: ctrl_reg <= reg_wdata;
        `ULCS_OFS_BIT_RATE: br_reg <= reg_wdata;
        // Receive and transmit thresholds sit above the read-only counts, where they read back; handshake threshold in bits 7:0
        `ULCS_OFS_RX_THRESH: rx_thresh_reg <= reg_wdata[13:8];
        `ULCS_OFS_TX_THRESH: tx_thresh_reg <= reg_wdata[15:8];
        `ULCS_OFS_HS_THRESH: hs_thresh_reg <= reg_wdata[7:0];
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Fractional bit-rate divider: tick at 16x the bit rate
  logic [15:0] acc_reg;
  logic [16:0] acc_sum;
  logic tick;
  assign acc_sum = {1'b0, acc_reg} + {1'b0, br_reg.divider_increment};
  assign tick = acc_sum >= {1'b0, br_reg.divider_modulus}; // see R25
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      acc_reg <= 16'h0000;
    end else if (tick) begin
      acc_reg <= 16'(acc_sum - {1'b0, br_reg.divider_modulus});
    end else begin
      acc_reg <= acc_sum[15:0];
    end
  end

  // ==========================================================
  // FIFOs
  logic [7:0] tx_mem [0:31];
  ulcs_pkg::ulcs_rx_entry_s rx_mem [0:31];
  logic [4:0] tx_wp_reg;
  logic [4:0] tx_rp_reg;
  logic [5:0] tx_cnt_reg;
  logic [4:0] rx_wp_reg;
  logic [4:0] rx_rp_reg;
  logic [5:0] rx_cnt_reg;
  logic tx_push;
  logic tx_pop;
  logic rx_push;
  logic rx_pop;
  logic rx_done;
  ulcs_pkg::ulcs_rx_entry_s rx_entry;
  logic [5:0] tx_free;

  assign tx_free = 6'(`ULCS_FIFO_DEPTH - tx_cnt_reg); // see R19
  assign tx_push = data_wr && ctrl_reg.transmit_enable && (tx_cnt_reg != `ULCS_FIFO_DEPTH); // see R8 see R12
  assign rx_push = rx_done && (rx_cnt_reg != `ULCS_FIFO_DEPTH); // see R11
  assign rx_pop = data_rd && (rx_cnt_reg != 6'h00);

  always_ff @(posedge mclk) begin
    if (tx_push) begin
      tx_mem[tx_wp_reg] <= reg_wdata[7:0]; // see R16
    end
    if (rx_push) begin
      rx_mem[rx_wp_reg] <= rx_entry;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      tx_wp_reg <= 5'h00;
      tx_rp_reg <= 5'h00;
      tx_cnt_reg <= 6'h00;
    end else begin
      tx_wp_reg <= tx_wp_reg + 5'(tx_push);
      tx_rp_reg <= tx_rp_reg + 5'(tx_pop);
      tx_cnt_reg <= 6'(tx_cnt_reg + 6'(tx_push) - 6'(tx_pop));
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      rx_wp_reg <= 5'h00;
      rx_rp_reg <= 5'h00;
      rx_cnt_reg <= 6'h00;
    end else begin
      rx_wp_reg <= rx_wp_reg + 5'(rx_push);
      rx_rp_reg <= rx_rp_reg + 5'(rx_pop);
      rx_cnt_reg <= 6'(rx_cnt_reg + 6'(rx_push) - 6'(rx_pop)); // see R17
    end
  end

  // ==========================================================
  // Transmitter
  ulcs_pkg::ulcs_tx_e tx_state_reg;
  logic [3:0] tx_os_reg;
  logic [2:0] tx_bit_reg;
  logic [7:0] tx_sh_reg;
  logic tx_par_reg;
  logic tx_stop2_reg;
  logic tx_line_reg;
  logic tx_bit_end;

  assign tx_bit_end = tick && (tx_os_reg == `ULCS_OVERSAMPLE);
  assign tx_pop = (tx_state_reg == ulcs_pkg::TX_IDLE) && ctrl_reg.transmit_enable &&
                  remote_ready && (tx_cnt_reg != 6'h00); // see R23

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      tx_state_reg <= ulcs_pkg::TX_IDLE;
      tx_os_reg <= 4'h0;
      tx_bit_reg <= 3'h0;
      tx_sh_reg <= 8'h00;
      tx_par_reg <= 1'b0;
      tx_stop2_reg <= 1'b0;
      tx_line_reg <= 1'b1;
    end else if (!ctrl_reg.transmit_enable) begin
      tx_state_reg <= ulcs_pkg::TX_IDLE; // see R7
      tx_line_reg <= 1'b1;
    end else begin
      if (tick) begin
        tx_os_reg <= tx_os_reg + 4'h1;
      end
      unique case (tx_state_reg)
        ulcs_pkg::TX_IDLE: begin
          tx_line_reg <= 1'b1;
          if (tx_pop) begin
            tx_sh_reg <= tx_mem[tx_rp_reg];
            tx_par_reg <= ~ctrl_reg.even_parity_select; // see R3
            tx_os_reg <= 4'h0;
            tx_line_reg <= 1'b0;
            tx_state_reg <= ulcs_pkg::TX_START;
          end
        end
        ulcs_pkg::TX_START: begin
          if (tx_bit_end) begin
            tx_line_reg <= tx_sh_reg[0];
            tx_bit_reg <= 3'h0;
            tx_state_reg <= ulcs_pkg::TX_DATA;
          end
        end
        ulcs_pkg::TX_DATA: begin
          if (tx_bit_end) begin
            tx_par_reg <= tx_par_reg ^ tx_sh_reg[0];
            tx_sh_reg <= {1'b0, tx_sh_reg[7:1]};
            tx_bit_reg <= tx_bit_reg + 3'h1;
            if (tx_bit_reg != 3'h7) begin
              tx_line_reg <= tx_sh_reg[1];
            end else if (ctrl_reg.parity_on) begin
              tx_line_reg <= tx_par_reg ^ tx_sh_reg[0]; // see R4
              tx_state_reg <= ulcs_pkg::TX_PAR;
            end else begin
              tx_line_reg <= 1'b1;
              tx_stop2_reg <= ctrl_reg.dual_stop_select;
              tx_state_reg <= ulcs_pkg::TX_STOP;
            end
          end
        end
        ulcs_pkg::TX_PAR: begin
          if (tx_bit_end) begin
            tx_line_reg <= 1'b1;
            tx_stop2_reg <= ctrl_reg.dual_stop_select;
            tx_state_reg <= ulcs_pkg::TX_STOP;
          end
        end
        ulcs_pkg::TX_STOP: begin
          if (tx_bit_end) begin
            tx_stop2_reg <= 1'b0;
            if (!tx_stop2_reg) begin
              tx_state_reg <= ulcs_pkg::TX_IDLE; // see R2
            end
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Receiver
  ulcs_pkg::ulcs_rx_e rx_state_reg;
  logic [3:0] rx_os_reg;
  logic [2:0] rx_bit_reg;
  logic [7:0] rx_sh_reg;
  logic rx_par_reg;
  logic rx_prev_reg;
  logic rx_armed_reg;
  logic rx_mid;
  logic fall;

  assign rx_mid = tick && (rx_os_reg == `ULCS_START_MID);
  assign fall = rx_prev_reg && !rx_bit;
  assign rx_done = rx_mid && (rx_state_reg == ulcs_pkg::RX_STOP);
  assign rx_entry.data = rx_sh_reg;
  assign rx_entry.stop_err = !rx_bit; // see R13
  assign rx_entry.par_err = ctrl_reg.parity_on && rx_par_reg; // see R14
  assign rx_entry.start_err = 1'b0;

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      rx_prev_reg <= 1'b1;
      rx_armed_reg <= 1'b0;
    end else begin
      rx_prev_reg <= rx_bit;
      // Arm only once the line has been seen high while enabled
      rx_armed_reg <= ctrl_reg.receive_enable && (rx_armed_reg || rx_bit); // see R5
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      rx_state_reg <= ulcs_pkg::RX_IDLE;
      rx_os_reg <= 4'h0;
      rx_bit_reg <= 3'h0;
      rx_sh_reg <= 8'h00;
      rx_par_reg <= 1'b0;
    end else begin
      if (tick) begin
        rx_os_reg <= rx_os_reg + 4'h1;
      end
      unique case (rx_state_reg)
        ulcs_pkg::RX_IDLE: begin
          if (fall && rx_armed_reg && ctrl_reg.receive_enable) begin
            rx_os_reg <= 4'h0;
            rx_par_reg <= ~ctrl_reg.even_parity_select; // see R3
            rx_state_reg <= ulcs_pkg::RX_START;
          end
        end
        ulcs_pkg::RX_START: begin
          if (rx_mid) begin
            rx_os_reg <= 4'h8;
            rx_bit_reg <= 3'h0;
            // Unconfirmed start is dropped as a glitch
            rx_state_reg <= rx_bit ? ulcs_pkg::RX_IDLE : ulcs_pkg::RX_DATA; // see R15
          end
        end
        ulcs_pkg::RX_DATA: begin
          if (rx_mid) begin
            rx_os_reg <= 4'h8;
            rx_sh_reg <= {rx_bit, rx_sh_reg[7:1]};
            rx_par_reg <= rx_par_reg ^ rx_bit;
            rx_bit_reg <= rx_bit_reg + 3'h1;
            if (rx_bit_reg == 3'h7) begin
              rx_state_reg <= ctrl_reg.parity_on ? ulcs_pkg::RX_PAR : ulcs_pkg::RX_STOP; // see R4
            end
          end
        end
        ulcs_pkg::RX_PAR: begin
          if (rx_mid) begin
            rx_os_reg <= 4'h8;
            rx_par_reg <= rx_par_reg ^ rx_bit;
            rx_state_reg <= ulcs_pkg::RX_STOP;
          end
        end
        ulcs_pkg::RX_STOP: begin
          // One stop bit checked; extra stop bits look like idle line
          if (rx_mid) begin
            rx_state_reg <= ulcs_pkg::RX_IDLE; // see R2 see R6
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Status flags and outputs
  logic start_miss;
  // Flagged in the cycle of the event so one status read clears it like the other error bits
  assign start_miss = (rx_state_reg == ulcs_pkg::RX_START) && rx_mid && rx_bit; // see R15

  // Layout: 5 underrun, 4 rx overrun, 3 tx overrun, 2 stop, 1 parity, 0 start
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      err_reg <= 6'h00;
      rx_byte_reg <= 8'h00;
    end else begin
      if (rx_pop) begin
        rx_byte_reg <= rx_mem[rx_rp_reg].data;
      end
      // A set in the same cycle as the status read wins
      err_reg[5] <= (data_rd && rx_cnt_reg == 6'h00) || (err_reg[5] && !status_rd); // see R10 see R9
      err_reg[4] <= (rx_done && !rx_push) || (err_reg[4] && !status_rd); // see R11
      err_reg[3] <= (data_wr && ctrl_reg.transmit_enable && !tx_push) || (err_reg[3] && !status_rd); // see R12
      err_reg[2] <= (rx_pop && rx_mem[rx_rp_reg].stop_err) || (err_reg[2] && !status_rd && !rx_pop); // see R13
      err_reg[1] <= ctrl_reg.parity_on &&
                    ((rx_pop && rx_mem[rx_rp_reg].par_err) || (err_reg[1] && !status_rd && !rx_pop)); // see R14
      err_reg[0] <= start_miss || (err_reg[0] && !status_rd); // see R15 see R9
    end
  end

  logic rx_irq;
  logic tx_irq;
  assign rx_irq = rx_cnt_reg > rx_thresh_reg; // see R18
  assign tx_irq = {2'h0, tx_free} > tx_thresh_reg; // see R20

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `ULCS_OFS_LINE_CONTROL: reg_rdata <= ctrl_reg;
        `ULCS_OFS_LINE_STATUS: reg_rdata <= {24'h0, tx_irq, rx_irq, err_reg}; // see R9
        `ULCS_OFS_DATA_PORT: reg_rdata <= {24'h0, rx_cnt_reg != 6'h00 ? rx_mem[rx_rp_reg].data : rx_byte_reg}; // see R16
        `ULCS_OFS_RX_THRESH: reg_rdata <= {18'h0, rx_thresh_reg, 2'h0, rx_cnt_reg}; // see R17
        `ULCS_OFS_TX_THRESH: reg_rdata <= {16'h0, tx_thresh_reg, 2'h0, tx_free}; // see R19
        `ULCS_OFS_HS_THRESH: reg_rdata <= {24'h0, hs_thresh_reg};
        `ULCS_OFS_BIT_RATE: reg_rdata <= br_reg;
        default: reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      txd <= 1'b1;
      cts <= 1'b0;
    end else begin
      // Disabling goes straight to idle without waiting for the state machine
      txd <= (tx_line_reg || !ctrl_reg.transmit_enable) && !ctrl_reg.force_break; // see R1 see R7
      // Asserted level equals polarity bit; drop when fill passes threshold
      cts <= (ctrl_reg.handshake_enable && ({2'h0, rx_cnt_reg} > hs_thresh_reg)) ?
             !ctrl_reg.handshake_polarity : ctrl_reg.handshake_polarity; // see R21 see R22 see R24
    end
  end
endmodule : ulcs_uart
`default_nettype wire

/* File: verif/ulcs_uart_properties.sv */
/*
  Port checker for the UART line control block, bound to ulcs_uart.
  Assumes the register map of ulcs_defs.svh and a synchronous active-low reset.
*/
`include "ulcs_defs.svh"
`timescale 1ns/10ps
`default_nettype none
module ulcs_uart_checker (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic rxd,
  input wire logic rts,
  input wire logic txd,
  input wire logic cts
);
  // ==========================================================
  // Control shadow
  // The second copy lines up with pins registered from the control register
  logic [9:0] ctl_reg;
  logic [9:0] ctl_dly_reg;
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      ctl_reg <= 10'h0;
      ctl_dly_reg <= 10'h0;
    end else begin
      if (reg_wr && reg_addr == `ULCS_OFS_LINE_CONTROL) begin
        ctl_reg <= reg_wdata[9:0];
      end
      ctl_dly_reg <= ctl_reg;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // ==========================================================
  // Properties
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data not zero outside a read");
  data_upper_a: assert property ($past(reg_rd) && $past(reg_addr) == 8'h08 |-> reg_rdata[31:8] == 24'h0)
    else $error("data port upper bits not zero");
  fill_bound_a: assert property ($past(reg_rd) && $past(reg_addr) == 8'h0c |-> reg_rdata[5:0] <= 6'h20)
    else $error("receive fill count above depth");
  free_bound_a: assert property ($past(reg_rd) && $past(reg_addr) == 8'h10 |-> reg_rdata[7:0] <= 8'h20)
    else $error("transmit free count above depth");
  cts_free_a: assert property (!ctl_dly_reg[8] |-> cts == ctl_dly_reg[9])
    else $error("clear to send not asserted without handshake");
  break_low_a: assert property (ctl_dly_reg[7] && ctl_dly_reg[2] |-> !txd)
    else $error("serial output high during break");
  tx_idle_a: assert property (!ctl_dly_reg[7] && !ctl_dly_reg[2] |-> txd)
    else $error("serial output not idle while transmitter off");
  start_len_a: assert property ($fell(txd) && ctl_dly_reg[7] && !ctl_dly_reg[2] |-> !txd [*8])
    else $error("start bit shorter than half a bit");
endmodule : ulcs_uart_checker
bind ulcs_uart ulcs_uart_checker CHK (.mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .rxd(rxd), .rts(rts), .txd(txd), .cts(cts));
`default_nettype wire

/* File: verif/ulcs_remote_uart.sv */
/*
  Remote UART model: frames characters onto rxd, decodes txd, drives rts.
  Assumes 16 clocks per bit, the divider reset value.
*/
`timescale 1ns/10ps
`default_nettype none
module ulcs_remote_uart (
  input wire logic mclk,
  output logic rxd,
  output logic rts,
  input wire logic txd,
  input wire logic cts
);
  localparam int BIT_CYC = 16;
  logic [10:0] got_q[$];
  logic par_on = 1'b0;
  logic dual_stop = 1'b0;
  logic obey_cts = 1'b0;
  initial begin
    rxd = 1'b1;
    rts = 1'b0;
  end
  // ==========================================================
  // Sender
  task automatic send(input logic [7:0] data, input logic even, input logic bad_par, input logic bad_stop);
    logic [10:0] bits;
    int n;
    n = par_on ? 11 : 10;
    bits = par_on ? {~bad_stop, ^data ^ ~even ^ bad_par, data, 1'b0} : {1'b1, ~bad_stop, data, 1'b0};
    while (obey_cts && cts) @(posedge mclk);
    for (int i = 0; i < n; i++) begin
      rxd <= bits[i];
      repeat (BIT_CYC) @(posedge mclk);
    end
    if (bad_stop) begin
      rxd <= 1'b1;
      repeat (BIT_CYC) @(posedge mclk);
    end
  endtask : send
  // Too short to survive the check at the start-bit centre
  task automatic glitch();
    rxd <= 1'b0;
    repeat (4) @(posedge mclk);
    rxd <= 1'b1;
    repeat (2 * BIT_CYC) @(posedge mclk);
  endtask : glitch
  // ==========================================================
  // Receiver: {stop2, stop1, parity, data}, sampled at bit centres
  always begin : catch_frames
    logic [10:0] frame;
    @(negedge txd);
    frame = 11'h0;
    repeat (BIT_CYC / 2) @(posedge mclk);
    for (int i = 0; i < 9; i++) begin
      if (i < 8 || par_on) begin
        repeat (BIT_CYC) @(posedge mclk);
        frame[i] = txd;
      end
    end
    repeat (BIT_CYC) @(posedge mclk);
    frame[9] = txd;
    frame[10] = 1'b1;
    if (dual_stop) begin
      repeat (BIT_CYC) @(posedge mclk);
      frame[10] = txd;
    end
    got_q.push_back(frame);
  end
endmodule : ulcs_remote_uart
`default_nettype wire

/* File: verif/ulcs_uart_test.sv */
/*
  Self-checking testbench for ulcs_uart with a remote UART model.
  Assumes the register map of ulcs_defs.svh and a 100 MHz clock.
*/
`include "ulcs_defs.svh"
`timescale 1ns/10ps
`default_nettype none
module ulcs_uart_test;
  localparam int LIMIT = 40000;
  localparam logic [7:0] A_CTL = `ULCS_OFS_LINE_CONTROL;
  localparam logic [7:0] A_ST = `ULCS_OFS_LINE_STATUS;
  localparam logic [7:0] A_DAT = `ULCS_OFS_DATA_PORT;
  localparam logic [7:0] A_RXT = `ULCS_OFS_RX_THRESH;
  localparam logic [7:0] A_TXT = `ULCS_OFS_TX_THRESH;
  logic mclk;
  logic reset_n;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_rdata;
  logic rxd;
  logic rts;
  logic txd;
  logic cts;
  logic [31:0] rv;
  logic [2:0] cfg;
  logic [7:0] tx_b[2] = '{8'h96, 8'h3b};
  int num_errors = 0;
  int n_checks = 0;
  int cycles = 0;
  ulcs_uart DUT (.mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rxd(rxd), .rts(rts), .txd(txd), .cts(cts));
  ulcs_remote_uart RMT (.mclk(mclk), .rxd(rxd), .rts(rts), .txd(txd), .cts(cts));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // ==========================================================
  // Bus and comparison tasks
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd
  task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    check(what, d & mask, exp);
  endtask : rchk
  task automatic results();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : results
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      num_errors++;
      results();
    end
  end
  // ==========================================================
  // Scenarios
  initial begin
    reset_n = 1'b0;
    reg_addr = 8'h0;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (4) @(posedge mclk);
    reset_n <= 1'b1;
    check("cts reset", 32'(cts), 32'h0);
    rchk("control", A_CTL, 32'hffff_ffff, `ULCS_CTRL_RESET);
    rchk("bit rate", `ULCS_OFS_BIT_RATE, 32'hffff_ffff, `ULCS_BR_RESET);
    rchk("status", A_ST, 32'hffff_ffff, 32'h80);
    rchk("fill", A_RXT, 32'h3f, 32'h0);
    rchk("free", A_TXT, 32'hff, 32'h20);
    wr(A_TXT, 32'h2000);
    rchk("tx thresh", A_TXT, 32'hff00, 32'h2000);
    rchk("tx irq at 32", A_ST, 32'h80, 32'h0);
    wr(A_TXT, 32'h1f00);
    wr(8'h1c, 32'hffff_ffff);
    rchk("unmapped", 8'h1c, 32'hffff_ffff, 32'h0);
    // Frame formats: {parity_on, even, dual stop}
    for (int m = 0; m < 3; m++) begin
      cfg = (m == 0) ? 3'b000 : ((m == 1) ? 3'b100 : 3'b111);
      RMT.par_on = cfg[2];
      RMT.dual_stop = cfg[0];
      RMT.got_q.delete();
      wr(A_CTL, {24'h0, 1'b1, 1'b0, cfg, 3'b000});
      wr(A_DAT, {24'habcdef, tx_b[0]});
      wr(A_DAT, {24'h123456, tx_b[1]});
      for (int k = 0; k < 1000 && RMT.got_q.size() < 2; k++) @(posedge mclk);
      for (int i = 0; i < 2; i++) begin
        check("frame", 32'(RMT.got_q[i]), 32'({2'b11, cfg[2] & (^tx_b[i] ^ ~cfg[1]), tx_b[i]}));
      end
    end
    // Abandon a character, then write while disabled
    wr(A_DAT, 32'h0);
    repeat (60) @(posedge mclk);
    wr(A_CTL, 32'h0);
    repeat (3) @(posedge mclk);
    check("txd abandoned", 32'(txd), 32'h1);
    wr(A_DAT, 32'h77);
    rchk("free tx off", A_TXT, 32'hff, 32'h20);
    wr(A_CTL, 32'h84);
    repeat (3) @(posedge mclk);
    check("txd break", 32'(txd), 32'h0);
    repeat (40) @(posedge mclk);
    wr(A_CTL, 32'h0);
    repeat (300) @(posedge mclk);
    RMT.got_q.delete();
    // Receiver enabled with the line already low
    RMT.par_on = 1'b1;
    RMT.dual_stop = 1'b0;
    RMT.rxd <= 1'b0;
    // Let the low level pass the synchroniser and vote before enabling
    repeat (8) @(posedge mclk);
    wr(A_CTL, 32'h60);
    repeat (200) @(posedge mclk);
    RMT.rxd <= 1'b1;
    repeat (20) @(posedge mclk);
    rchk("fill no edge", A_RXT, 32'h3f, 32'h0);
    rd(A_ST, rv);
    RMT.send(8'h5a, 1'b0, 1'b0, 1'b0);
    repeat (4) @(posedge mclk);
    rchk("fill one", A_RXT, 32'h3f, 32'h1);
    rchk("rx irq", A_ST, 32'hc0, 32'hc0);
    rchk("byte", A_DAT, 32'hffff_ffff, 32'h5a);
    rchk("clean status", A_ST, 32'h3f, 32'h0);
    rd(A_DAT, rv);
    rchk("underrun", A_ST, 32'h7f, 32'h20);
    rchk("status cleared", A_ST, 32'h3f, 32'h0);
    for (int m = 0; m < 2; m++) begin
      RMT.send(8'hc3, 1'b0, m == 0, m == 1);
      repeat (4) @(posedge mclk);
      rd(A_ST, rv);
      rchk("error byte", A_DAT, 32'hffff_ffff, 32'hc3);
      rchk("error flag", A_ST, 32'h3f, (m == 0) ? 32'h2 : 32'h4);
    end
    RMT.glitch();
    rchk("start error", A_ST, 32'h3f, 32'h1);
    rchk("glitch dropped", A_RXT, 32'h3f, 32'h0);
    // Fill past depth with handshake on; remote ignores clear-to-send
    wr(`ULCS_OFS_HS_THRESH, 32'h2);
    wr(A_RXT, 32'h1f00);
    wr(A_CTL, 32'h160);
    for (int i = 0; i < 33; i++) begin
      RMT.send(8'(i), 1'b0, 1'b0, 1'b0);
      if (i == 1 || i == 2) begin
        repeat (8) @(posedge mclk);
        check("cts vs fill", 32'(cts), 32'(i == 2));
      end
    end
    repeat (8) @(posedge mclk);
    rchk("fill full", A_RXT, 32'h3f, 32'h20);
    rchk("overrun", A_ST, 32'h50, 32'h50);
    wr(A_RXT, 32'h2000);
    rchk("rx irq at 32", A_ST, 32'h40, 32'h0);
    for (int i = 0; i < 32; i++) begin
      rchk("drain", A_DAT, 32'hffff_ffff, 32'(i));
    end
    rchk("fill empty", A_RXT, 32'h3f, 32'h0);
    check("cts free", 32'(cts), 32'h0);
    // Transmit overrun and pause on remote not ready
    RMT.par_on = 1'b0;
    RMT.got_q.delete();
    RMT.rts <= 1'b1;
    wr(A_CTL, 32'h180);
    for (int i = 0; i < 34; i++) wr(A_DAT, 32'(i + 8'h40));
    rchk("free full", A_TXT, 32'hff, 32'h0);
    rchk("tx overrun", A_ST, 32'h88, 32'h08);
    RMT.rts <= 1'b0;
    for (int k = 0; k < 100 && txd; k++) @(posedge mclk);
    repeat (40) @(posedge mclk);
    RMT.rts <= 1'b1;
    repeat (400) @(posedge mclk);
    check("paused count", 32'(RMT.got_q.size()), 32'h1);
    check("paused frame", 32'(RMT.got_q[0]), 32'h640);
    wr(A_CTL, 32'h80);
    repeat (400) @(posedge mclk);
    check("rts ignored", 32'(RMT.got_q.size() >= 2), 32'h1);
    wr(A_CTL, 32'h0);
    results();
  end
endmodule : ulcs_uart_test
`default_nettype wire
